// ==== verilog/svm_pkg.sv ====
`default_nettype none
package svm_pkg;
	localparam logic [7:0] SVM_MON_ADDR      = 8'h11;
	localparam int         SVM_OK_BIT        = 5;
	localparam int         SVM_HR_BIT        = 4;
	localparam int         SVM_SPARE_BIT     = 6;
	localparam logic [3:0] SVM_VTH_RST       = 4'h2;
	localparam logic       SVM_HR_RST        = 1'b0;
	localparam logic       SVM_SPARE_RST     = 1'b0;
	localparam logic       SVM_OK_RST        = 1'b0;
	// Threshold table in millivolts: base and step per range
	localparam int         SVM_HI_BASE_MV    = 2550;
	localparam int         SVM_HI_STEP_MV    = 75;
	localparam int         SVM_LO_BASE_MV    = 1700;
	localparam int         SVM_LO_STEP_MV    = 50;
	localparam int         SVM_SYNC_STAGES   = 2;
	// Transceiver power states; the monitor runs only in SVM_ST_ACTIVE and sleeps in the other three
	typedef enum logic [1:0] {
		SVM_ST_ACTIVE,
		SVM_ST_POWER_ON,
		SVM_ST_SLEEP,
		SVM_ST_DEEP
	} svm_pwr_t;
endpackage
`default_nettype wire

// ==== verilog/svm_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module svm_sync #(
	parameter int STAGES = 2
) (
	input  wire logic clock,
	input  wire logic arst_n,
	input  wire logic clk_en,
	input  wire logic async_in,
	output logic      sync_out
);
	logic [STAGES-1:0] chain_r;

	initial begin
		if (STAGES < 2) $error("svm_sync needs at least two stages");
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			chain_r <= '0;
		end else if (clk_en) begin
			chain_r <= {chain_r[STAGES-2:0], async_in};
		end
	end

	assign sync_out = chain_r[STAGES-1];
endmodule
`default_nettype wire

// ==== verilog/svm_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Flag reads 1 when supply above threshold, 0 when below.
// - Range bit 1 selects 75mV steps, 0 selects 50mV steps.
// - High range maps code 0x0 at 2.550V to 0xF at 3.675V.
// - Low range maps code zero at 1.70V to top code at 2.45V.
// - Low-supply event fires only on flag falling from one to zero.
// - Flag never one since power-on means no event.
// - New threshold still above supply with flag low raises no event.
// - Monitor inactive in power-on, sleep and deepest low-power states.
// - Read-only flag at bit 5 of register 0x11, resets to 0.
// - Range bit 4 resets 0; threshold code bits 3..0 reset 0x2.
// - Supply compared to threshold in active state; falling below clears flag, fires event.
module svm_monitor
	import svm_pkg::*;
(
	// Clock, reset, enable
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire logic              clk_en,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic              reg_wr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// Power state of the transceiver
	input  wire svm_pkg::svm_pwr_t transceiver_state_field,
	// Analog comparator interface
	input  wire logic              external_supply_pin,
	output logic                   supply_monitor_enable,
	output logic      [11:0]       threshold_mv,
	output logic                   high_range_select,
	output logic      [3:0]        threshold_code,
	// Event and flag
	output logic                   supply_above_threshold,
	output logic                   supply_low_event
);
	import svm_pkg::*;

	// ************************************************
	// Register decode
	// ************************************************
	logic [3:0] vth_r;
	logic       hr_r;
	logic       spare_r;
	logic       ok_r;
	logic       evt_r;
	logic [7:0] rdata_q_r;
	logic       cmp_sync;
	logic       mon_active;
	logic       hit;
	logic       wr_hit;
	logic       fall;
	logic       ok_nxt;
	logic [7:0] rd_mux;

	assign hit    = (reg_addr == SVM_MON_ADDR);
	assign wr_hit = hit && reg_wr;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			vth_r   <= SVM_VTH_RST;
			hr_r    <= SVM_HR_RST;
			spare_r <= SVM_SPARE_RST;
		end else if (clk_en && wr_hit) begin
			vth_r   <= reg_wdata[3:0];
			hr_r    <= reg_wdata[SVM_HR_BIT];
			spare_r <= reg_wdata[SVM_SPARE_BIT];
		end
	end

	// Bit 7 reserved reads zero; flag is read only
	assign rd_mux = {1'b0, spare_r, ok_r, hr_r, vth_r};

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q_r <= 8'h00;
		end else if (clk_en && reg_rd) begin
			rdata_q_r <= hit ? rd_mux : 8'h00;
		end
	end
	assign reg_rdata = rdata_q_r;

	// ************************************************
	// Threshold selection
	// ************************************************
	// Comparator reference, in millivolts, for the analog side
	assign threshold_mv = hr_r
		? 12'(SVM_HI_BASE_MV + SVM_HI_STEP_MV * int'(vth_r))
		: 12'(SVM_LO_BASE_MV + SVM_LO_STEP_MV * int'(vth_r));
	assign high_range_select = hr_r;
	assign threshold_code    = vth_r;

	// ************************************************
	// Comparator capture and event
	// ************************************************
	assign mon_active = (transceiver_state_field == SVM_ST_ACTIVE);
	assign supply_monitor_enable = mon_active;

	// Comparator is asynchronous to the core clock
	svm_sync #(
		.STAGES   (SVM_SYNC_STAGES)
	) u_sync (
		.clock    (clock),
		.arst_n   (arst_n),
		.clk_en   (clk_en),
		.async_in (external_supply_pin),
		.sync_out (cmp_sync)
	);

	// Flag holds its last value while the monitor sleeps
	assign ok_nxt = mon_active ? cmp_sync : ok_r;
	// Only a one-to-zero step fires; a flag that stays low never does
	assign fall   = ok_r && !ok_nxt;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ok_r  <= SVM_OK_RST;
			evt_r <= 1'b0;
		end else if (clk_en) begin
			ok_r  <= ok_nxt;
			evt_r <= fall;
		end
	end

	assign supply_above_threshold = ok_r;
	assign supply_low_event       = evt_r;

	// ************************************************
	// Checks
	// ************************************************
	a_event_on_fall: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && $past(clk_en) && supply_low_event |-> $past(ok_r) && !ok_r)
		else $error("event without falling flag");

	a_fall_gives_event: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && ok_r && !ok_nxt |=> !clk_en || supply_low_event)
		else $error("falling flag did not fire event");

	a_low_no_event: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && !ok_r && !supply_low_event |=> !clk_en || !supply_low_event)
		else $error("event while flag stayed low");

	a_sleep_holds: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && !mon_active |=> $stable(ok_r))
		else $error("flag moved while monitor inactive");

	a_flag_tracks: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && mon_active |=> !clk_en || ok_r == $past(cmp_sync))
		else $error("flag does not follow comparator");

	a_thr_hi: assert property (@(posedge clock) disable iff (!arst_n)
		hr_r |-> threshold_mv == 12'(2550 + 75 * int'(vth_r)))
		else $error("high range threshold wrong");

	a_thr_lo: assert property (@(posedge clock) disable iff (!arst_n)
		!hr_r |-> threshold_mv == 12'(1700 + 50 * int'(vth_r)))
		else $error("low range threshold wrong");

	a_write_fields: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && wr_hit |=> vth_r == $past(reg_wdata[3:0]) && hr_r == $past(reg_wdata[4]))
		else $error("register write not stored");

	a_read_flag: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && reg_rd && hit |=> reg_rdata[5] == $past(ok_r) && !reg_rdata[7])
		else $error("read data flag wrong");

	a_write_no_evt: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && wr_hit && !ok_r |=> !supply_low_event)
		else $error("threshold write fired event with low flag");

	a_enable_freeze: assert property (@(posedge clock) disable iff (!arst_n)
		!clk_en |=> $stable(ok_r) && $stable(supply_low_event) && $stable(vth_r) && $stable(hr_r))
		else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// ==== verif/svm_monitor_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
	$display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module svm_monitor_test;
	import svm_pkg::*;
	logic       clock;
	logic       arst_n;
	logic       clk_en;
	logic [7:0] reg_addr;
	logic       reg_wr;
	logic [7:0] reg_wdata;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	svm_pwr_t   state;
	logic       pin;
	logic       enable;
	logic [11:0] thr_mv;
	logic       hr;
	logic [3:0] code;
	logic       flag;
	logic       event_out;
	logic [7:0] rd_val;
	int         mismatches = 0;
	int         check_count = 0;
	int         ev_n = 0;
	svm_monitor dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transceiver_state_field(state),
		.external_supply_pin(pin), .supply_monitor_enable(enable), .threshold_mv(thr_mv),
		.high_range_select(hr), .threshold_code(code), .supply_above_threshold(flag),
		.supply_low_event(event_out));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Sampled mid-cycle so the registered pulse has settled
	always @(negedge clock) if (event_out === 1'b1) ev_n++;
	task print_verdict;
		if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	initial begin
		#200000;
		mismatches++;
		print_verdict;
	end
	// ********************
	// Main sequence
	// ********************
	initial begin
		arst_n = 1'b0; clk_en = 1'b1; reg_addr = 8'h00; reg_wr = 1'b0; reg_wdata = 8'h00;
		reg_rd = 1'b0; state = SVM_ST_ACTIVE; pin = 1'b0;
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		rd(SVM_MON_ADDR, rd_val);
		`CHK("reset value", 8'h02, rd_val)
		`CHK("default mv", 12'h708, thr_mv)
		cyc(6);
		`CHK("no event from reset", 0, ev_n)
		wr(8'h10, 8'hFF);
		rd(8'h10, rd_val);
		`CHK("unmapped read", 8'h00, rd_val)
		wr(SVM_MON_ADDR, 8'hFF);
		rd(SVM_MON_ADDR, rd_val);
		`CHK("read-only flag", 8'h5F, rd_val)
		for (int i = 0; i < 32; i++) begin
			wr(SVM_MON_ADDR, 8'(i));
			`CHK("range", i[4], hr)
			`CHK("code", i[3:0], code)
			`CHK("mv", (i[4] ? 12'(SVM_HI_BASE_MV + SVM_HI_STEP_MV * i[3:0])
				: 12'(SVM_LO_BASE_MV + SVM_LO_STEP_MV * i[3:0])), thr_mv)
		end
		wr(SVM_MON_ADDR, 8'h02);
		pin <= 1'b1;
		cyc(4);
		`CHK("flag high", 1'b1, flag)
		rd(SVM_MON_ADDR, rd_val);
		`CHK("flag bit", 8'h22, rd_val)
		@(posedge clock);
		pin <= 1'b0;
		cyc(2);
		`CHK("flag after sync", 1'b1, flag)
		cyc(1);
		`CHK("flag low", 1'b0, flag)
		`CHK("event pulse", 1'b1, event_out)
		cyc(3);
		`CHK("one event", 1, ev_n)
		wr(SVM_MON_ADDR, 8'h1F);
		cyc(5);
		`CHK("no event on rewrite", 1, ev_n)
		for (int s = 0; s < 4; s++) begin
			@(posedge clock);
			state <= svm_pwr_t'(s);
			cyc(1);
			`CHK("enable", (s == 0), enable)
		end
		pin <= 1'b1;
		cyc(6);
		`CHK("frozen in deep", 1'b0, flag)
		state <= SVM_ST_ACTIVE;
		cyc(4);
		`CHK("active again", 1'b1, flag)
		state <= SVM_ST_SLEEP;
		pin <= 1'b0;
		cyc(6);
		`CHK("frozen in sleep", 1'b1, flag)
		`CHK("no event asleep", 1, ev_n)
		state <= SVM_ST_ACTIVE;
		cyc(5);
		`CHK("event on wake", 2, ev_n)
		clk_en <= 1'b0;
		pin <= 1'b1;
		wr(SVM_MON_ADDR, 8'h03);
		cyc(4);
		`CHK("frozen flag", 1'b0, flag)
		`CHK("frozen code", 4'hF, code)
		clk_en <= 1'b1;
		cyc(4);
		`CHK("flag after enable", 1'b1, flag)
		arst_n <= 1'b0;
		cyc(2);
		`CHK("reset code", 4'h2, code)
		`CHK("reset flag", 1'b0, flag)
		arst_n <= 1'b1;
		cyc(4);
		`CHK("flag after reset", 1'b1, flag)
		`CHK("no event on rise", 2, ev_n)
		pin <= 1'b0;
		cyc(4);
		`CHK("event after reset", 3, ev_n)
		print_verdict;
	end
endmodule
`default_nettype wire
